//--- core/ptm_pkg.sv
package ptm_pkg;

  // ==========================================================================
  // stream geometry
  // ==========================================================================
  localparam int AXIS_W   = 256;  // one of 64/128/256; 256 keeps a request in one beat
  localparam int KEEP_W   = 8;
  localparam int REGION_N = 4;
  localparam int RAM_WORDS = 512; // 2 KB of 32-bit words per region
  localparam int WADDR_W  = 9;
  localparam int BADDR_W  = 12;

  // ==========================================================================
  // completer request descriptor fields
  // ==========================================================================
  localparam int DESC_DWCNT_LSB = 64;
  localparam int DWCNT_W        = 11;
  localparam int DESC_RTYPE_LSB = 75;
  localparam int DESC_REQID_LSB = 80;
  localparam int DESC_TAG_LSB   = 96;
  localparam int DESC_BAR_LSB   = 112;
  localparam int DESC_TC_LSB    = 121;
  localparam int DESC_ATTR_LSB  = 124;
  localparam int PAYLOAD_LSB    = 128;
  localparam logic [DWCNT_W-1:0] ONE_DWORD = 11'h001;

  localparam logic [3:0] RT_MEM_RD = 4'h0;
  localparam logic [3:0] RT_MEM_WR = 4'h1;
  localparam logic [3:0] RT_IO_RD  = 4'h2;
  localparam logic [3:0] RT_IO_WR  = 4'h3;

  localparam logic [2:0] BAR_MEM32 = 3'h0;
  localparam logic [2:0] BAR_MEM64 = 3'h1;
  localparam logic [2:0] BAR_EROM  = 3'h6;
  localparam logic [2:0] BAR_TRIG  = 3'h0;

  localparam logic [1:0] REG_IO    = 2'h0;
  localparam logic [1:0] REG_MEM32 = 2'h1;
  localparam logic [1:0] REG_MEM64 = 2'h2;
  localparam logic [1:0] REG_EROM  = 2'h3;

  // ==========================================================================
  // magic writes
  // ==========================================================================
  localparam logic [BADDR_W-1:0] TRIG_MRD_ADDR = 12'hea8;
  localparam logic [BADDR_W-1:0] TRIG_INT_ADDR = 12'heec;
  localparam logic [31:0] TRIG_MRD_DATA  = 32'haaaa_bbbb;
  localparam logic [31:0] TRIG_LEG_DATA  = 32'hcccc_dddd;
  localparam logic [31:0] TRIG_MSI_DATA  = 32'heeee_ffff;
  localparam logic [31:0] TRIG_MSIX_DATA = 32'hdead_beef;

  // ==========================================================================
  // completer completion descriptor fields
  // ==========================================================================
  localparam int CC_LADDR_LSB  = 0;
  localparam int CC_BCNT_LSB   = 16;
  localparam int CC_DWCNT_LSB  = 32;
  localparam int CC_STATUS_LSB = 43;
  localparam int CC_REQID_LSB  = 48;
  localparam int CC_TAG_LSB    = 64;
  localparam int CC_TC_LSB     = 89;
  localparam int CC_ATTR_LSB   = 92;
  localparam int CC_DATA_LSB   = 96;
  localparam logic [2:0]  CPL_SC      = 3'h0;
  localparam logic [12:0] CPL_BCNT    = 13'h004;
  localparam logic [KEEP_W-1:0] KEEP_CPLD = 8'h0f;
  localparam logic [KEEP_W-1:0] KEEP_CPL  = 8'h07;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DRAIN = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ  = 3'b011,
    ST_RDATA = 3'b100,
    ST_CPL   = 3'b101
  } ptm_state_e;

  typedef struct packed {
    logic [1:0]         region;
    logic [WADDR_W-1:0] widx;
    logic [BADDR_W-1:0] baddr;
    logic [3:0]         rtype;
    logic [2:0]         bar;
    logic [31:0]        data;
    logic [15:0]        reqid;
    logic [7:0]         tag;
    logic [2:0]         tc;
    logic [2:0]         attr;
  } ptm_req_s;

endpackage : ptm_pkg

//--- core/ptm_pio_target.sv
`timescale 1ns/1ps

// Contract
// - four 2 KB regions, 8192 bytes total
// - single-Dword I/O and memory 32/64 access
// - each valid read gets one-Dword completion
// - I/O write gets successful no-data completion
// - one-Dword writes store payload in region
// - BAR0 write EA8/AAAABBBB starts memory read
// - BAR0 write EEC/CCCCDDDD raises legacy interrupt
// - BAR0 write EEC/EEEEFFFF raises MSI
// - BAR0 write EEC/DEADBEEF raises MSI-X
// - BAR identifier selects region; I/O off
// - each region its own dual-port RAM
// - variants for 64, 128, 256-bit paths; only the 256-bit path is built
// - longer requests drained, dropped, no completion
// - ready low while write or read busy
// - accesses past 2 KB wrap onto region
module ptm_pio_target #(
  parameter logic IO_EN = 1'b0
) (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // completer request stream
  input  wire logic [ptm_pkg::AXIS_W-1:0]  cq_tdata,
  input  wire logic                        cq_tvalid,
  input  wire logic                        cq_tlast,
  output logic                             completer_request_ready,
  // completer completion stream
  output logic [ptm_pkg::AXIS_W-1:0]       cc_tdata,
  output logic [ptm_pkg::KEEP_W-1:0]       cc_tkeep,
  output logic                             cc_tvalid,
  output logic                             cc_tlast,
  input  wire logic                        cc_tready,
  // outbound request pulses
  output logic                             mem_read_req,
  output logic                             legacy_intr_req,
  output logic                             msi_req,
  output logic                             msix_req
);
  import ptm_pkg::*;

  // ==========================================================================
  // request decode
  // ==========================================================================
  ptm_state_e         state_r;
  ptm_state_e         state_nxt;
  ptm_req_s           req_r;
  ptm_req_s           req_d;
  logic               ready_r;
  logic               region_ok;
  logic               single_dw;
  logic               accept;
  logic [DWCNT_W-1:0] dw_cnt;
  logic [31:0]        rd_q [REGION_N];
  logic [AXIS_W-1:0]  cc_tdata_r;
  logic [KEEP_W-1:0]  cc_tkeep_r;
  logic               cc_tvalid_r;
  logic               cc_tlast_r;
  logic               mem_read_req_r;
  logic               legacy_intr_req_r;
  logic               msi_req_r;
  logic               msix_req_r;
  logic               trig_bar;

  assign accept    = cq_tvalid && ready_r;
  assign dw_cnt    = cq_tdata[DESC_DWCNT_LSB +: DWCNT_W];
  assign single_dw = (dw_cnt == ONE_DWORD);

  // field extraction; upper address bits are ignored so a wide aperture wraps
  always_comb begin
    req_d        = '0;
    req_d.baddr  = {cq_tdata[BADDR_W-1:2], 2'b00};
    req_d.widx   = cq_tdata[2 +: WADDR_W];
    req_d.rtype  = cq_tdata[DESC_RTYPE_LSB +: 4];
    req_d.bar    = cq_tdata[DESC_BAR_LSB +: 3];
    req_d.data   = cq_tdata[PAYLOAD_LSB +: 32];
    req_d.reqid  = cq_tdata[DESC_REQID_LSB +: 16];
    req_d.tag    = cq_tdata[DESC_TAG_LSB +: 8];
    req_d.tc     = cq_tdata[DESC_TC_LSB +: 3];
    req_d.attr   = cq_tdata[DESC_ATTR_LSB +: 3];
    region_ok    = 1'b1;
    case (req_d.rtype)
      RT_IO_RD, RT_IO_WR: begin
        req_d.region = REG_IO;
        region_ok    = IO_EN;
      end
      RT_MEM_RD, RT_MEM_WR: begin
        case (req_d.bar)
          BAR_MEM32: req_d.region = REG_MEM32;
          BAR_MEM64: req_d.region = REG_MEM64;
          BAR_EROM:  req_d.region = REG_EROM;
          default:   region_ok    = 1'b0;
        endcase
      end
      default: region_ok = 1'b0;
    endcase
  end

  // ==========================================================================
  // receive state machine
  // ==========================================================================
  // only one request in flight keeps the control trivial; throughput is not a goal
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (accept) begin
          if (!cq_tlast) begin
            state_nxt = ST_DRAIN;
          end else if (single_dw && region_ok) begin
            state_nxt = req_d.rtype[0] ? ST_WRITE : ST_READ;
          end
        end
      end
      ST_DRAIN: begin
        if (accept && cq_tlast) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_WRITE: state_nxt = (req_r.rtype == RT_IO_WR) ? ST_CPL : ST_IDLE;
      ST_READ:  state_nxt = ST_RDATA;
      ST_RDATA: state_nxt = ST_CPL;
      ST_CPL: begin
        if (cc_tready) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state and held request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      req_r   <= '0;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && accept) begin
        req_r <= req_d;
      end
    end
  end

  // ready drops the edge a single-Dword request for an enabled region is taken and stays low until done; drained or dropped requests leave it high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_r <= 1'b0;
    end else begin
      ready_r <= (state_nxt == ST_IDLE) || (state_nxt == ST_DRAIN);
    end
  end

  // ==========================================================================
  // region memories
  // ==========================================================================
  // one 512 x 32 dual-port array per region: write port and read port apart
  for (genvar g = 0; g < REGION_N; g++) begin : g_region
    logic [31:0] ram [RAM_WORDS];
    always_ff @(posedge clk) begin
      if (state_r == ST_WRITE && req_r.region == 2'(g)) begin
        ram[req_r.widx] <= req_r.data;
      end
      rd_q[g] <= ram[req_r.widx];
    end
  end

  // ==========================================================================
  // completion builder
  // ==========================================================================
  function automatic logic [AXIS_W-1:0] build_cc(input ptm_req_s r, input logic with_data,
                                                 input logic [31:0] dw);
    logic [AXIS_W-1:0] t;
    t = '0;
    t[CC_LADDR_LSB +: 7]   = (r.region == REG_IO) ? 7'h00 : r.baddr[6:0];
    t[CC_BCNT_LSB +: 13]   = CPL_BCNT;
    t[CC_DWCNT_LSB +: 11]  = with_data ? ONE_DWORD : 11'h000;
    t[CC_STATUS_LSB +: 3]  = CPL_SC;
    t[CC_REQID_LSB +: 16]  = r.reqid;
    t[CC_TAG_LSB +: 8]     = r.tag;
    t[CC_TC_LSB +: 3]      = r.tc;
    t[CC_ATTR_LSB +: 3]    = r.attr;
    t[CC_DATA_LSB +: 32]   = with_data ? dw : 32'h0000_0000;
    return t;
  endfunction : build_cc

  // completion beat held until the core takes it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cc_tdata_r  <= '0;
      cc_tkeep_r  <= '0;
      cc_tvalid_r <= 1'b0;
      cc_tlast_r  <= 1'b0;
    end else if (state_r == ST_RDATA) begin
      cc_tdata_r  <= build_cc(req_r, 1'b1, rd_q[req_r.region]);
      cc_tkeep_r  <= KEEP_CPLD;
      cc_tvalid_r <= 1'b1;
      cc_tlast_r  <= 1'b1;
    end else if (state_r == ST_WRITE && req_r.rtype == RT_IO_WR) begin
      cc_tdata_r  <= build_cc(req_r, 1'b0, 32'h0000_0000);
      cc_tkeep_r  <= KEEP_CPL;
      cc_tvalid_r <= 1'b1;
      cc_tlast_r  <= 1'b1;
    end else if (state_r == ST_CPL && cc_tready) begin
      cc_tvalid_r <= 1'b0;
      cc_tlast_r  <= 1'b0;
    end
  end

  // ==========================================================================
  // magic-write triggers
  // ==========================================================================
  assign trig_bar = (state_r == ST_WRITE) && (req_r.bar == BAR_TRIG);

  // one-cycle pulses; the write itself still lands in the memory
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_read_req_r    <= 1'b0;
      legacy_intr_req_r <= 1'b0;
      msi_req_r         <= 1'b0;
      msix_req_r        <= 1'b0;
    end else begin
      mem_read_req_r    <= trig_bar && req_r.baddr == TRIG_MRD_ADDR && req_r.data == TRIG_MRD_DATA;
      legacy_intr_req_r <= trig_bar && req_r.baddr == TRIG_INT_ADDR && req_r.data == TRIG_LEG_DATA;
      msi_req_r         <= trig_bar && req_r.baddr == TRIG_INT_ADDR && req_r.data == TRIG_MSI_DATA;
      msix_req_r        <= trig_bar && req_r.baddr == TRIG_INT_ADDR && req_r.data == TRIG_MSIX_DATA;
    end
  end

  assign completer_request_ready = ready_r;
  assign cc_tdata        = cc_tdata_r;
  assign cc_tkeep        = cc_tkeep_r;
  assign cc_tvalid       = cc_tvalid_r;
  assign cc_tlast        = cc_tlast_r;
  assign mem_read_req    = mem_read_req_r;
  assign legacy_intr_req = legacy_intr_req_r;
  assign msi_req         = msi_req_r;
  assign msix_req        = msix_req_r;

  // ==========================================================================
  // checks
  // ==========================================================================
  a_ready_busy_low: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r inside {ST_WRITE, ST_READ, ST_RDATA, ST_CPL}) |-> !completer_request_ready)
    else $error("request ready high while busy");

  a_read_cpl_time: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_READ) |-> ##2 (cc_tvalid && cc_tkeep == KEEP_CPLD && cc_tlast
      && cc_tdata[CC_DWCNT_LSB +: 11] == ONE_DWORD))
    else $error("read completion not one dword two cycles on");

  a_iow_cpl_ok: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_WRITE && req_r.rtype == RT_IO_WR) |=> (cc_tvalid && cc_tkeep == KEEP_CPL
      && cc_tdata[CC_STATUS_LSB +: 3] == CPL_SC))
    else $error("io write completion missing or bad status");

  a_long_dropped: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_IDLE && accept && !single_dw) |=> !cc_tvalid [*3])
    else $error("completion produced for long request");

  a_write_follows: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_IDLE && accept && cq_tlast && single_dw && region_ok && req_d.rtype[0])
      |=> (state_r == ST_WRITE && req_r.data == $past(cq_tdata[PAYLOAD_LSB +: 32])))
    else $error("write not carried out with accepted payload");

  a_mrd_trigger: assert property (@(posedge clk) disable iff (sys_rst)
    (trig_bar && req_r.baddr == TRIG_MRD_ADDR && req_r.data == TRIG_MRD_DATA) |=> mem_read_req ##1 !mem_read_req)
    else $error("memory read trigger not a single pulse");

  a_legacy_trigger: assert property (@(posedge clk) disable iff (sys_rst)
    legacy_intr_req |-> $past(trig_bar) && $past(req_r.data) == TRIG_LEG_DATA
      && $past(req_r.baddr) == TRIG_INT_ADDR)
    else $error("legacy interrupt without its magic write");

  a_msi_trigger: assert property (@(posedge clk) disable iff (sys_rst)
    (trig_bar && req_r.baddr == TRIG_INT_ADDR && req_r.data == TRIG_MSI_DATA) |=> (msi_req && !msix_req))
    else $error("msi trigger missed");

  a_msix_trigger: assert property (@(posedge clk) disable iff (sys_rst)
    (trig_bar && req_r.baddr == TRIG_INT_ADDR && req_r.data == TRIG_MSIX_DATA) |=> (msix_req && !msi_req))
    else $error("msix trigger missed");

  a_cpl_held: assert property (@(posedge clk) disable iff (sys_rst)
    (cc_tvalid && !cc_tready) |=> (cc_tvalid && $stable(cc_tdata)))
    else $error("completion dropped before taken");

endmodule : ptm_pio_target

//--- verif/ptm_core_model.sv
`timescale 1ns/1ps

// ====================
// core-side model: issues requests, sinks completions
// ====================
module ptm_core_model (
  // clock
  input  wire logic                       clk,
  // request stream toward the target
  output logic [ptm_pkg::AXIS_W-1:0]      cq_tdata,
  output logic                            cq_tvalid,
  output logic                            cq_tlast,
  input  wire logic                       completer_request_ready,
  // completion stream from the target
  input  wire logic [ptm_pkg::AXIS_W-1:0] cc_tdata,
  input  wire logic [ptm_pkg::KEEP_W-1:0] cc_tkeep,
  input  wire logic                       cc_tvalid,
  input  wire logic                       cc_tlast,
  output logic                            cc_tready
);
  import ptm_pkg::*;
  int                stall = 0;  // hold-off cycles per completion
  int                n     = 0;  // completions taken
  int                lost  = 0;  // requests never accepted
  int                cnt   = 0;
  logic [AXIS_W-1:0] last  = '0;
  logic [KEEP_W-1:0] lkeep = '0;
  logic              llast = 1'b0;  // last flag of the taken beat

  // idle levels at time zero
  initial begin
    cq_tdata = '0;
    cq_tvalid = 1'b0;
    cq_tlast = 1'b0;
    cc_tready = 1'b0;
  end

  // completion sink; slow answers come only from stall
  always @(posedge clk) begin
    if (cc_tvalid && cc_tready) begin
      last      <= cc_tdata;
      lkeep     <= cc_tkeep;
      llast     <= cc_tlast;
      n         <= n + 1;
      cc_tready <= 1'b0;
      cnt       <= 0;
    end else if (cc_tvalid) begin
      cnt       <= cnt + 1;
      cc_tready <= (cnt >= stall);
    end
  end

  // one request beat, the last one unless lst is cleared, held until the edge that sees ready
  task automatic send(input logic [3:0] rt, input logic [2:0] bar, input logic [11:0] a,
                      input logic [10:0] dw, input logic [31:0] d, input logic lst = 1'b1);
    logic [AXIS_W-1:0] t;
    int                k;
    t = '0;
    t[11:0] = a;
    t[DESC_DWCNT_LSB +: DWCNT_W] = dw;
    t[DESC_RTYPE_LSB +: 4] = rt;
    t[DESC_TAG_LSB +: 8] = 8'h5a;
    t[DESC_BAR_LSB +: 3] = bar;
    t[PAYLOAD_LSB +: 32] = d;
    @(posedge clk);
    cq_tdata  <= t;
    cq_tvalid <= 1'b1;
    cq_tlast  <= lst;  // a cleared last flag opens a multi-beat request
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (completer_request_ready === 1'b1) break;
    end
    if (k == 50) lost++;
    cq_tvalid <= 1'b0;
    cq_tlast  <= 1'b0;
    cq_tdata  <= ~t;  // released bus must not look like a request
  endtask : send
endmodule : ptm_core_model

//--- verif/pcie_pio_target_memory_tb_top.sv
`timescale 1ns/1ps

// ====================
// bench top
// ====================
module pcie_pio_target_memory_tb_top;
  import ptm_pkg::*;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic [AXIS_W-1:0] cq_tdata;
  logic [AXIS_W-1:0] cc_tdata;
  logic [KEEP_W-1:0] cc_tkeep;
  logic              cq_tvalid;
  logic              cq_tlast;
  logic              rdy;
  logic              cc_tvalid;
  logic              cc_tlast;
  logic              cc_tready;
  logic [3:0]        trig;
  int                failures = 0;
  int                checked = 0;
  int                tcnt [4] = '{default: 0};

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // io region enabled so every request type is reachable
  ptm_pio_target #(.IO_EN(1'b1)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .cq_tdata(cq_tdata), .cq_tvalid(cq_tvalid),
    .cq_tlast(cq_tlast), .completer_request_ready(rdy), .cc_tdata(cc_tdata),
    .cc_tkeep(cc_tkeep), .cc_tvalid(cc_tvalid), .cc_tlast(cc_tlast), .cc_tready(cc_tready),
    .mem_read_req(trig[0]), .legacy_intr_req(trig[1]), .msi_req(trig[2]), .msix_req(trig[3]));

  ptm_core_model m (
    .clk(clk), .cq_tdata(cq_tdata), .cq_tvalid(cq_tvalid), .cq_tlast(cq_tlast),
    .completer_request_ready(rdy), .cc_tdata(cc_tdata), .cc_tkeep(cc_tkeep),
    .cc_tvalid(cc_tvalid), .cc_tlast(cc_tlast), .cc_tready(cc_tready));

  // count high cycles of each trigger; a stuck pulse shows as more than one
  always @(posedge clk) begin
    for (int j = 0; j < 4; j++) if (trig[j] === 1'b1) tcnt[j]++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic summarize();
    $display("checked %0d failures %0d lost %0d", checked, failures, m.lost);
    if (failures + m.lost == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // bounded wait for one more completion
  task automatic await(input int n0);
    int k;
    for (k = 0; k < 40; k++) begin
      @(posedge clk);
      #1;
      if (m.n != n0) break;
    end
    if (k == 40) begin
      chk(32'h0, 32'h1, "completion never came");
      summarize();
    end
  endtask : await

  // a request that is never taken ends the run at once
  always @(posedge clk) begin
    if (m.lost != 0) begin
      chk(32'(m.lost), 32'h0, "request never taken");
      summarize();
    end
  end

  task automatic rd(input logic [3:0] rt, input logic [2:0] bar, input logic [11:0] a,
                    input logic [31:0] exp);
    int n0;
    n0 = m.n;
    m.send(rt, bar, a, ONE_DWORD, 32'h0);
    #1;
    chk(32'(rdy), 32'h0, "ready while busy");
    await(n0);
    chk(m.last[CC_DATA_LSB +: 32], exp, "read data");
    chk(32'(m.lkeep), 32'(KEEP_CPLD), "read keep");
    chk(32'(m.last[CC_DWCNT_LSB +: 11]), 32'h1, "read dword count");
    chk(32'(m.llast), 32'h1, "read last flag");
  endtask : rd

  // distinct data at one offset in every region, io write answered, slow sink
  task automatic t_regions();
    int n0;
    m.send(RT_MEM_WR, BAR_MEM32, 12'h010, ONE_DWORD, 32'h1111_0001);
    m.send(RT_MEM_WR, BAR_MEM64, 12'h010, ONE_DWORD, 32'h2222_0002);
    m.send(RT_MEM_WR, BAR_EROM, 12'h010, ONE_DWORD, 32'h3333_0003);
    m.stall = 4;
    n0 = m.n;
    m.send(RT_IO_WR, 3'h0, 12'h010, ONE_DWORD, 32'h4444_0004);
    await(n0);
    chk(32'(m.lkeep), 32'(KEEP_CPL), "io write keep");
    chk(32'(m.last[CC_STATUS_LSB +: 3]), 32'(CPL_SC), "io write status");
    rd(RT_MEM_RD, BAR_MEM32, 12'h010, 32'h1111_0001);
    m.stall = 0;
    rd(RT_MEM_RD, BAR_MEM64, 12'h010, 32'h2222_0002);
    rd(RT_MEM_RD, BAR_EROM, 12'h010, 32'h3333_0003);
    rd(RT_IO_RD, 3'h0, 12'h010, 32'h4444_0004);
  endtask : t_regions

  // offsets past 2 KB land on the same words
  task automatic t_wrap();
    m.send(RT_MEM_WR, BAR_MEM64, 12'h814, ONE_DWORD, 32'h5a5a_0814);
    rd(RT_MEM_RD, BAR_MEM64, 12'h014, 32'h5a5a_0814);
    m.send(RT_MEM_WR, BAR_MEM64, 12'hffc, ONE_DWORD, 32'ha5a5_0ffc);
    rd(RT_MEM_RD, BAR_MEM64, 12'h7fc, 32'ha5a5_0ffc);
  endtask : t_wrap

  // long and misdirected requests are swallowed without an answer
  task automatic t_drop();
    int n0;
    n0 = m.n;
    m.send(RT_MEM_RD, BAR_MEM32, 12'h010, 11'h002, 32'h0);
    m.send(RT_MEM_RD, 3'h2, 12'h010, ONE_DWORD, 32'h0);
    // two-beat write: neither beat may store or be answered
    m.send(RT_MEM_WR, BAR_MEM32, 12'h010, 11'h002, 32'h0bad_0010, 1'b0);
    m.send(RT_MEM_RD, BAR_MEM32, 12'h010, ONE_DWORD, 32'h0, 1'b1);
    repeat (10) @(posedge clk);
    chk(32'(m.n), 32'(n0), "dropped request answered");
    rd(RT_MEM_RD, BAR_MEM32, 12'h010, 32'h1111_0001);
  endtask : t_drop

  // each magic write on BAR 0 fires its own pulse once; the last entry aims at BAR 001 and fires none
  task automatic t_trig();
    logic [11:0] ta [5] = '{TRIG_MRD_ADDR, TRIG_INT_ADDR, TRIG_INT_ADDR, TRIG_INT_ADDR, TRIG_INT_ADDR};
    logic [31:0] td [5] = '{TRIG_MRD_DATA, TRIG_LEG_DATA, TRIG_MSI_DATA, TRIG_MSIX_DATA, TRIG_MSIX_DATA};
    logic [2:0]  tbar [5] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h1};
    int          s [4];
    for (int i = 0; i < 5; i++) begin
      s = tcnt;
      m.send(RT_MEM_WR, tbar[i], ta[i], ONE_DWORD, td[i]);
      repeat (5) @(posedge clk);
      for (int j = 0; j < 4; j++) chk(32'(tcnt[j] - s[j]), 32'(i == j), "trigger pulses");
    end
  endtask : t_trig

  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_regions();
    t_wrap();
    t_drop();
    t_trig();
    summarize();
  end
endmodule : pcie_pio_target_memory_tb_top
